// File: cucs_chain.v
// Summary of operation
// RQ1: Data window write stages low six bits.
// RQ2: Staged bits enter chain only at retire.
// RQ3: After trigger, window read returns chain bits.
// RQ4: Trigger bit zero moves six bits out.
// RQ5: Software keeps duplicate fields equal to originals.
// RQ6: Vector LSB sits first in chain.
// RQ7: Boot chain ordered from LSB upward.
// RQ8: Ratio flag set for 1.5x board cache.
// RQ9: Staggered fill required at 1.5x ratio.
// RQ10: Stream victims once count reaches threshold.
// RQ11: At most six pending victims; decoded threshold.
// RQ12: Clock multiplier field decoded one-hot.
// RQ13: Fast-movement disable blocks fast mode.
// RQ14: Clean-evict enable sends clean victims out.
// RQ15: Ack inhibit stops victim-read ack counting.
// RQ16: Barrier forward sends barriers off chip.
// RQ17: Board-cache idle gaps from chain fields.
// RQ18: Shadow tag enable selects duplicate tag mode.
// RQ19: Probe-tag-only bit selects that mode.
// RQ20: Victim-read pin mode from chain bit.
// RQ21: Bus width and layout from boot chain.
// RQ22: Ack and victim limits held from chain.
// RQ23: Bank enable marks board cache banked.
// RQ24: Reset loads 367 ROM bits, MSB first.
// RQ25: Runtime chain advances six per write.
// RQ26: Trigger destructively shifts error chain out.
// RQ27: Reserved bits read zero, writes ignored.
// RQ28: Software reads whole error chain in groups.
`include "cucs_consts.vh"
module cucs_chain (
	mclk,
	resetn,
	boot_bit,
	boot_busy,
	priv_wr,
	priv_sel,
	priv_wdata,
	priv_retire,
	priv_rdata,
	err_capture,
	err_capture_vld,
	run_chain,
	victim_add,
	victim_take,
	victim_stream,
	victim_count,
	io32_en,
	cache_ratio_flag,
	staggered_fill_en,
	clean_evict_en,
	sys_addr_bus_width,
	sys_bus_layout,
	mult_1p5,
	mult_2p0,
	mult_2p5,
	mult_3p0,
	shadow_tag_en,
	probe_tag_only_en,
	fast_move_en,
	victim_read_pin_mode,
	victim_read_ack_inhibit,
	barrier_forward_en,
	sys_ack_limit,
	sys_victim_limit,
	write_write_gap,
	read_write_gap,
	read_read_gap,
	banked_cache_en
);
	input  wire                      mclk;
	input  wire                      resetn;
	input  wire                      boot_bit;
	output wire                      boot_busy;
	input  wire                      priv_wr;
	input  wire                      priv_sel;
	input  wire [63:0]               priv_wdata;
	input  wire                      priv_retire;
	output wire [63:0]               priv_rdata;
	input  wire [`CUCS_ERR_LEN-1:0]  err_capture;
	input  wire                      err_capture_vld;
	output wire [`CUCS_RUN_LEN-1:0]  run_chain;
	input  wire                      victim_add;
	input  wire                      victim_take;
	output wire                      victim_stream;
	output wire [3:0]                victim_count;
	output wire                      io32_en;
	output wire                      cache_ratio_flag;
	output wire                      staggered_fill_en;
	output wire                      clean_evict_en;
	output wire [1:0]                sys_addr_bus_width;
	output wire                      sys_bus_layout;
	output wire                      mult_1p5;
	output wire                      mult_2p0;
	output wire                      mult_2p5;
	output wire                      mult_3p0;
	output wire                      shadow_tag_en;
	output wire                      probe_tag_only_en;
	output wire                      fast_move_en;
	output wire                      victim_read_pin_mode;
	output wire                      victim_read_ack_inhibit;
	output wire                      barrier_forward_en;
	output wire [4:0]                sys_ack_limit;
	output wire [2:0]                sys_victim_limit;
	output wire                      write_write_gap;
	output wire [5:0]                read_write_gap;
	output wire                      read_read_gap;
	output wire                      banked_cache_en;

	// Boot bit comes from the serial ROM pin, so it is synchronised.
	reg                            boot_s1_q;
	reg                            boot_s2_q;
	reg [`CUCS_BOOT_LEN-1:0]       boot_q;
	reg [`CUCS_BOOT_CNT_W-1:0]     boot_cnt_q;
	reg                            boot_busy_q;
	// Privileged port state: staged group, window and the two chains.
	reg [`CUCS_GRP_W-1:0]          stage_q;
	reg                            stage_vld_q;
	reg [`CUCS_GRP_W-1:0]          window_q;
	reg [`CUCS_RUN_LEN-1:0]        run_q;
	reg [`CUCS_ERR_LEN-1:0]        err_q;
	// Victim bookkeeping.
	reg [3:0]                      vcount_q;
	reg [3:0]                      vcount_d;

	// =================================================================
	// Boot load
	// Bits arrive MSB first: each enters at bit 0 and moves upward, so
	// after all bits the last one sent, the first-listed field, sits at
	// bit 0 and the leading surplus bits have moved to the top end.
	// The privileged port is not gated by the load, so software that
	// reads configuration taps must first wait for boot_busy to fall.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			boot_s1_q   <= 1'b0;
			boot_s2_q   <= 1'b0;
			boot_q      <= {`CUCS_BOOT_LEN{1'b0}};
			boot_cnt_q  <= {`CUCS_BOOT_CNT_W{1'b0}};
			boot_busy_q <= 1'b1;
		end else begin
			boot_s1_q <= boot_bit;
			boot_s2_q <= boot_s1_q;
			if (boot_busy_q) begin
				boot_q     <= {boot_q[`CUCS_BOOT_LEN-2:0], boot_s2_q}; // RQ24
				boot_cnt_q <= boot_cnt_q + 9'h001;
				if (boot_cnt_q == `CUCS_BOOT_LAST)
					boot_busy_q <= 1'b0; // RQ24
			end
		end
	end

	assign boot_busy = boot_busy_q;

	// =================================================================
	// Privileged register port
	// Decoded privileged writes; a trigger needs its low bit set.
	wire                           data_wr;
	wire                           trig_wr;
	assign data_wr = priv_wr && priv_sel == `CUCS_SEL_DATA; // RQ1
	assign trig_wr = priv_wr && priv_sel == `CUCS_SEL_SHIFT &&
		priv_wdata[`CUCS_SHIFT_BIT]; // RQ4

	// A data window write only stages bits; the chain moves at retire.
	// A retire that finds nothing staged is ignored, so a stray retire
	// from an unrelated instruction cannot push stale bits in again.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			stage_q     <= {`CUCS_GRP_W{1'b0}};
			stage_vld_q <= 1'b0;
			window_q    <= {`CUCS_GRP_W{1'b0}};
			run_q       <= {`CUCS_RUN_LEN{1'b0}};
			err_q       <= {`CUCS_ERR_LEN{1'b0}};
		end else begin
			if (data_wr) begin
				stage_q     <= priv_wdata[`CUCS_GRP_W-1:0]; // RQ1 RQ27
				stage_vld_q <= 1'b1;
			end else if (priv_retire) begin
				stage_vld_q <= 1'b0;
			end
			if (priv_retire && stage_vld_q) begin
				// Six bits per retired write, LSB first.
				run_q <= {stage_q, run_q[`CUCS_RUN_LEN-1:`CUCS_GRP_W]}; // RQ2 RQ25 RQ6
			end
			if (err_capture_vld) begin
				err_q <= err_capture;
			end else if (trig_wr) begin
				// Destructive unload: low group out, zeros in at top.
				window_q <= err_q[`CUCS_GRP_W-1:0]; // RQ4 RQ26
				err_q    <= {{`CUCS_GRP_W{1'b0}},
					err_q[`CUCS_ERR_LEN-1:`CUCS_GRP_W]}; // RQ26
			end
		end
	end

	// Reads show the unloaded group; upper bits are zero.
	assign priv_rdata = {58'h0, window_q}; // RQ3 RQ27
	assign run_chain  = run_q;

	// =================================================================
	// Victim accumulation
	// Pending count saturates at six; streaming starts when the count
	// reaches the threshold, whose bit n means "threshold n+1".
	// Simultaneous add and take leave the count unchanged.
	always @* begin
		vcount_d = vcount_q;
		if (victim_add && !victim_take && vcount_q < `CUCS_VICT_MAX)
			vcount_d = vcount_q + 4'h1; // RQ11
		else if (victim_take && !victim_add && vcount_q != 4'h0)
			vcount_d = vcount_q - 4'h1;
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn)
			vcount_q <= 4'h0;
		else
			vcount_q <= vcount_d;
	end

	// Highest decoded threshold bit gives the threshold count.
	function [3:0] thr_count;
		input [7:0] pat;
		integer i;
		begin
			thr_count = 4'h0;
			for (i = 0; i < 8; i = i + 1)
				if (pat[i])
					thr_count = i[3:0] + 4'h1;
		end
	endfunction

	// The threshold pattern is decoded once into a count to compare.
	wire [7:0]                     vthr_field;
	wire [3:0]                     vthr_count;
	assign vthr_field    = boot_q[`CUCS_B_VTHR+7:`CUCS_B_VTHR]; // RQ11
	assign vthr_count    = thr_count(vthr_field); // RQ11
	assign victim_count  = vcount_q;
	// No streaming during the load, while the threshold still moves.
	assign victim_stream = !boot_busy_q && vcount_q != 4'h0 &&
		vcount_q >= vthr_count; // RQ10 RQ11

	// =================================================================
	// Configuration fields from the boot chain
	// Every field is a tap, plain, inverted or decoded, on the boot register, so each output
	// settles as soon as the load is over and holds until reset.
	// While the load runs the taps show bits still in flight; users
	// must wait for boot_busy to fall before trusting any of them.

	// True when a multiplier field holds exactly the given code.
	function code_is;
		input [3:0] field;
		input [3:0] code;
		begin
			code_is = (field == code);
		end
	endfunction

	// The multiplier field, taken once for all four selects.
	wire [3:0]                     sclk_field;
	assign sclk_field = boot_q[`CUCS_B_SCLK+3:`CUCS_B_SCLK]; // RQ12

	// Leading fields: wide I/O, board-cache ratio and staggered fill.
	assign io32_en            = boot_q[`CUCS_B_IO32]; // RQ7
	assign cache_ratio_flag   = boot_q[`CUCS_B_RATIO]; // RQ7
	assign staggered_fill_en  = boot_q[`CUCS_B_STAGGER]; // RQ7

	// Clean victims and the shape of the system bus.
	assign clean_evict_en     = boot_q[`CUCS_B_CLEAN]; // RQ14
	assign sys_addr_bus_width = boot_q[`CUCS_B_ABUS+1:`CUCS_B_ABUS]; // RQ21
	assign sys_bus_layout     = boot_q[`CUCS_B_LAYOUT]; // RQ21

	// System clock multiplier, one select per legal code.
	// Illegal codes select nothing, so no ratio is ever doubly chosen.
	assign mult_1p5 = code_is(sclk_field, 4'h1); // RQ12
	assign mult_2p0 = code_is(sclk_field, 4'h2); // RQ12
	assign mult_2p5 = code_is(sclk_field, 4'h4); // RQ12
	assign mult_3p0 = code_is(sclk_field, 4'h8); // RQ12

	// Tag modes and the fast data path. The field is a disable bit,
	// so the enable output is its inverse.
	assign shadow_tag_en        = boot_q[`CUCS_B_SHADOW]; // RQ18
	assign probe_tag_only_en    = boot_q[`CUCS_B_PROBE]; // RQ19
	assign fast_move_en         = !boot_q[`CUCS_B_FASTDIS]; // RQ13

	// Victim-read, acknowledge and barrier controls on the system port.
	assign victim_read_pin_mode = boot_q[`CUCS_B_VRPIN]; // RQ20
	assign victim_read_ack_inhibit = boot_q[`CUCS_B_ACKINH]; // RQ15
	assign barrier_forward_en   = boot_q[`CUCS_B_BARRIER]; // RQ16

	// Limits on outstanding system acknowledges and victims.
	assign sys_ack_limit    = boot_q[`CUCS_B_ACKLIM+4:`CUCS_B_ACKLIM]; // RQ22
	assign sys_victim_limit = boot_q[`CUCS_B_VICLIM+2:`CUCS_B_VICLIM]; // RQ22

	// Board-cache idle gaps between reads and writes.
	assign write_write_gap  = boot_q[`CUCS_B_WWGAP]; // RQ17
	assign read_write_gap   = boot_q[`CUCS_B_RWGAP+5:`CUCS_B_RWGAP]; // RQ17
	assign read_read_gap    = boot_q[`CUCS_B_RRGAP]; // RQ17

	// Bank mode for the board cache.
	assign banked_cache_en  = boot_q[`CUCS_B_BANK]; // RQ23

endmodule

// File: cucs_consts.vh
`ifndef CUCS_CONSTS_VH
`define CUCS_CONSTS_VH
// =====================================================================
// Chain geometry.
`define CUCS_GRP_W        6
`define CUCS_BOOT_LEN     367
`define CUCS_RUN_LEN      36
`define CUCS_ERR_LEN      60
`define CUCS_BOOT_CNT_W   9
`define CUCS_BOOT_LAST    9'h16E
// =====================================================================
// Register selects on the privileged move port.
`define CUCS_SEL_DATA     1'b0
`define CUCS_SEL_SHIFT    1'b1
`define CUCS_SHIFT_BIT    0
// =====================================================================
// Boot chain field positions, counted from the last bit shifted in.
`define CUCS_B_IO32       0
`define CUCS_B_RATIO      1
`define CUCS_B_STAGGER    2
`define CUCS_B_VTHR       3
`define CUCS_B_CLEAN      11
`define CUCS_B_ABUS       12
`define CUCS_B_LAYOUT     14
`define CUCS_B_SCLK       15
`define CUCS_B_SHADOW     19
`define CUCS_B_PROBE      20
`define CUCS_B_FASTDIS    21
`define CUCS_B_VRPIN      22
`define CUCS_B_CLEAN2     23
`define CUCS_B_ACKINH     24
`define CUCS_B_BARRIER    25
`define CUCS_B_ACKLIM     26
`define CUCS_B_VICLIM     31
`define CUCS_B_CLEAN3     34
`define CUCS_B_WWGAP      35
`define CUCS_B_RWGAP      36
`define CUCS_B_RRGAP      42
`define CUCS_B_BANK       43
`define CUCS_VICT_MAX     4'h6
`endif

// File: cucs_chain_properties.sv
// ========
// Port checker for the chain block.
module cucs_chk (
	input wire        mclk,
	input wire        resetn,
	input wire        boot_busy,
	input wire        priv_wr,
	input wire        priv_sel,
	input wire [63:0] priv_wdata,
	input wire        priv_retire,
	input wire [63:0] priv_rdata,
	input wire        err_capture_vld,
	input wire [35:0] run_chain,
	input wire [3:0]  victim_count,
	input wire        victim_stream,
	input wire [4:0]  sys_ack_limit
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [8:0] boot_n_q;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	// Counts boot shift edges and stops at the chain length.
	always @(posedge mclk or negedge resetn)
		if (!resetn)
			boot_n_q <= 9'h000;
		else if (boot_n_q != 9'h16F)
			boot_n_q <= boot_n_q + 9'h001;
	boot_len_a: assert property ((boot_n_q == 9'h16F) == !boot_busy)
		else $error("boot length wrong");
	run_hold_a: assert property (!priv_retire |=> $stable(run_chain))
		else $error("chain moved without retire");
	run_shift_a: assert property (priv_wr && !priv_sel ##1
		priv_retire && !priv_wr |=> run_chain ==
		{$past(priv_wdata[5:0], 2), $past(run_chain[35:6])})
		else $error("chain shift wrong");
	rsvd_zero_a: assert property (priv_rdata[63:6] == 58'h0)
		else $error("reserved read bits set");
	trig_zero_a: assert property (priv_wr && priv_sel &&
		!priv_wdata[0] && !err_capture_vld |=> $stable(priv_rdata))
		else $error("zero trigger moved data");
	vic_max_a: assert property (victim_count <= 4'h6)
		else $error("victim count above six");
	stream_why_a: assert property (victim_stream |->
		victim_count != 4'h0 && !boot_busy)
		else $error("stream without victims");
	cfg_hold_a: assert property (!boot_busy |=>
		!boot_busy && $stable(sys_ack_limit))
		else $error("config changed after boot");
	cover property ($fell(boot_busy));
	cover property (priv_retire);
	cover property (victim_count == 4'h6);
endmodule
bind cucs_chain cucs_chk chk_u (.*);

// File: cucs_core_model.sv
// ========
// Core side: issues privileged moves and retires window writes.
module cucs_core_model (
	input  wire         mclk,
	input  wire         resetn,
	input  wire         req,
	input  wire         req_sel,
	input  wire  [63:0] req_data,
	input  wire         slow,
	output logic        priv_wr,
	output logic        priv_sel,
	output logic [63:0] priv_wdata,
	output logic        priv_retire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] pend_q;
	// An idle data bus toggles so stale data is never mistaken for new.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			{priv_wr, priv_sel, priv_wdata, pend_q, priv_retire} <= '0;
		end else begin
			priv_wr <= req;
			priv_sel <= req ? req_sel : priv_sel;
			priv_wdata <= req ? req_data : ~priv_wdata;
			pend_q <= {req & ~req_sel & slow,
				(req & ~req_sel & ~slow) | pend_q[1]};
			priv_retire <= pend_q[0];
		end
	end
endmodule

// File: tb_top.sv
// ========
// Self-checking bench for the chain block.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, resetn = 1'b0, boot_bit = 1'b0, req = 1'b0;
	logic req_sel = 1'b0, slow = 1'b0, err_capture_vld = 1'b0;
	logic victim_add = 1'b0, victim_take = 1'b0, add, take;
	logic [63:0] req_data = 64'h0;
	logic [59:0] err_capture = 60'h0, xe;
	logic [366:0] rom;
	logic [35:0] xr = 36'h0;
	logic [31:0] sd = 32'h00010300;
	logic [3:0] vc = 4'h0;
	int fails = 0, tests_run = 0, ecnt = 0;
	wire boot_busy, priv_wr, priv_sel, priv_retire, victim_stream;
	wire [63:0] priv_wdata, priv_rdata;
	wire [35:0] run_chain;
	wire [3:0] victim_count;
	wire io32_en, cache_ratio_flag, staggered_fill_en, clean_evict_en;
	wire [1:0] sys_addr_bus_width;
	wire sys_bus_layout, mult_1p5, mult_2p0, mult_2p5, mult_3p0;
	wire shadow_tag_en, probe_tag_only_en, fast_move_en, barrier_forward_en;
	wire victim_read_pin_mode, victim_read_ack_inhibit;
	wire [4:0] sys_ack_limit;
	wire [2:0] sys_victim_limit;
	wire write_write_gap, read_read_gap, banked_cache_en;
	wire [5:0] read_write_gap;
	cucs_chain dut_u (.*);
	cucs_core_model core_u (.*);
	always #2.5 mclk = ~mclk;
	// Boot stream leads each shift edge by three edges.
	always @(posedge mclk) begin
		ecnt <= ecnt + 1;
		if (ecnt >= 1 && ecnt <= 367)
			boot_bit <= rom[367 - ecnt];
	end
	function automatic logic [31:0] nxt(input logic [31:0] s);
		for (int i = 0; i < 32; i++)
			s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		return s;
	endfunction
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic op(input logic s, input logic [63:0] d, input logic l);
		@(posedge mclk);
		{req, req_sel, req_data, slow} <= {1'b1, s, d, l};
		@(posedge mclk);
		req <= 1'b0;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task automatic give_verdict;
		if (fails == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Main sequence: boot, runtime chain, error chain, victims.
	initial begin
		for (int i = 0; i < 367; i++) begin
			sd = nxt(sd);
			rom[i] = sd[0];
		end
		rom[2] = rom[2] | rom[1];
		rom[18:15] = 4'h4;
		rom[10:3] = 8'h04;
		rom[23] = rom[11];
		rom[34] = rom[11];
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		repeat (370) @(posedge mclk);
		#1;
		chk(boot_busy, 0);
		chk({sys_bus_layout, sys_addr_bus_width, clean_evict_en,
			staggered_fill_en, cache_ratio_flag, io32_en},
			{rom[14:11], rom[2:0]});
		chk({mult_3p0, mult_2p5, mult_2p0, mult_1p5}, 4'h4);
		chk({banked_cache_en, read_read_gap, read_write_gap, write_write_gap,
			clean_evict_en, sys_victim_limit, sys_ack_limit},
			rom[43:26]);
		chk({barrier_forward_en, victim_read_ack_inhibit, victim_read_pin_mode,
			~fast_move_en, probe_tag_only_en, shadow_tag_en},
			{rom[25:24], rom[22:19]});
		for (int i = 0; i < 8; i++) begin
			sd = nxt(sd);
			op(1'b0, {sd, sd}, sd[7]);
			xr = {sd[5:0], xr[35:6]};
			chk(run_chain, xr);
		end
		xe = {sd[27:0], nxt(sd)};
		@(posedge mclk);
		{err_capture, err_capture_vld} <= {xe, 1'b1};
		@(posedge mclk);
		err_capture_vld <= 1'b0;
		op(1'b1, {sd, 32'hFFFFFFFE}, 1'b0);
		for (int i = 0; i < 11; i++) begin
			op(1'b1, {sd, 32'h00000001}, 1'b0);
			chk(priv_rdata, xe[5:0]);
			xe = xe >> 6;
		end
		for (int i = 0; i < 40; i++) begin
			sd = nxt(sd);
			add = i < 8 || sd[0];
			take = !add && vc != 4'h0;
			@(posedge mclk);
			{victim_add, victim_take} <= {add, take};
			@(posedge mclk);
			{victim_add, victim_take} <= 2'h0;
			#1;
			vc = vc + (add && vc != 4'h6) - take;
			chk({victim_stream, victim_count}, {vc >= 4'h3, vc});
		end
		give_verdict();
	end
endmodule
